// [logic/gms_pkg.sv]
package gms_pkg;

   // Register byte offsets on the bus.
   localparam logic [7:0] ADR_CTRL = 8'h00;
   localparam logic [7:0] ADR_MAINS_MAX = 8'h04;
   localparam logic [7:0] ADR_TIE_MAX = 8'h08;
   localparam logic [7:0] ADR_OFFSET = 8'h0c;
   localparam logic [7:0] ADR_STATUS = 8'h10;
   localparam logic [7:0] ADR_EFFECT = 8'h14;

   // Control register fields.
   localparam int CTRL_W = 10;
   localparam int CTRL_MODE_LO = 0;
   localparam int CTRL_AUTO_MAN = 2;
   localparam int CTRL_FAIL_ACT = 3;
   localparam int CTRL_TIE_MANAGED = 4;
   localparam int CTRL_PRECOND = 5;
   localparam int CTRL_AI_VOLT = 6;
   localparam int CTRL_AI_SPEED = 7;
   localparam int CTRL_MAN_SEL_MAINS = 8;
   localparam int CTRL_EXT_SYNC = 9;
   localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;

   // Status register fields.
   localparam int ST_MAINS_WARN = 0;
   localparam int ST_TIE_ANOM = 1;
   localparam int ST_TIE_ALARM = 2;
   localparam int ST_MAINS_SYNC = 3;
   localparam int ST_TIE_SYNC = 4;
   localparam int ST_SYNCED = 5;
   localparam int ST_SHIFT = 6;
   localparam int ST_HOLD = 7;

   // Offset register layout and limits, in percent.
   localparam int OFS_VOLT_LO = 0;
   localparam int OFS_SPEED_LO = 8;
   localparam int PCT_W = 7;
   localparam logic [PCT_W-1:0] PCT_NOMINAL = 7'h32;
   localparam logic [PCT_W-1:0] PCT_MAX = 7'h64;

   // Timing.
   localparam int TIME_W = 16;
   localparam logic [TIME_W-1:0] TIME_RST = 16'h0000;
   localparam int CLK_PERIOD_NS = 20;
   localparam int SEC_NS = 1000000000;
   localparam int CYC_PER_SEC = SEC_NS / CLK_PERIOD_NS;
   localparam logic [TIME_W-1:0] PERSIST_S = 16'h000a;
   localparam logic [TIME_W-1:0] SHIFT_S = 16'h0002;

   typedef enum logic [1:0] {
      MODE_MAN = 2'h0,
      MODE_AUTO = 2'h1,
      MODE_TEST = 2'h2,
      MODE_REMOTE = 2'h3
   } gms_mode_e;

   typedef enum logic [4:0] {
      S_IDLE = 5'h01,
      S_SYNC = 5'h02,
      S_SHIFT = 5'h04,
      S_HOLD = 5'h08,
      S_UNSYNC = 5'h10
   } gms_state_e;

endpackage : gms_pkg

// [logic/gms_sync3.sv]
`timescale 1ns/1ns
module gms_sync3 #(
   parameter int N = 1
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst,
   // Pins in, filtered levels out.
   input wire logic [N-1:0] pin,
   output logic [N-1:0] level
);

   typedef struct packed {
      logic [N-1:0] f1;
      logic [N-1:0] f2;
      logic [N-1:0] f3;
      logic [N-1:0] o;
   } gms_sync3_s;

   gms_sync3_s q, d;

   initial begin
      if (N < 1) $error("gms_sync3: N must be at least 1.");
   end

   // A change is taken only when the second and third stages agree, so a glitch is dropped.
   always_comb begin
      d = q;
      d.f1 = pin;
      d.f2 = q.f1;
      d.f3 = q.f2;
      for (int i = 0; i < N; i++) begin
         if (q.f2[i] == q.f3[i]) d.o[i] = q.f3[i];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) q <= '0;
      else q <= d;
   end

   assign level = q.o;

endmodule : gms_sync3

// [logic/gms_sec_timer.sv]
`timescale 1ns/1ns
module gms_sec_timer
   import gms_pkg::*;
#(
   parameter int W = TIME_W
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst,
   // Control.
   input wire logic tick,
   input wire logic run,
   input wire logic [W-1:0] limit,
   // Result.
   output logic [W-1:0] elapsed,
   output logic expired
);

   typedef struct packed {
      logic [W-1:0] cnt;
   } gms_tmr_s;

   gms_tmr_s q, d;

   initial begin
      if (W < 2 || W > 31) $error("gms_sec_timer: W out of range.");
   end

   // The count saturates, so a long stall never wraps into a false fresh start.
   always_comb begin
      d = q;
      if (!run) d.cnt = '0;
      else if (tick && q.cnt != {W{1'b1}}) d.cnt = q.cnt + 1'b1;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) q <= '0;
      else q <= d;
   end

   assign elapsed = q.cnt;
   // A zero limit means no supervision.
   assign expired = run && (limit != '0) && (q.cnt >= limit);

endmodule : gms_sec_timer

// [logic/gms_sequencer.sv]
// Implementation choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ns
// What this block does
// - Request plus preconditions starts internal regulated sync
// - Tie enable output follows tie sync
// - Mains enable output follows mains sync
// - In-progress output covers any sync process
// - Synchronized output only during sync and in-phase
// - Three status bits exposed to logic combiner
// - Auto sync in auto, test, remote, manual-with-flag
// - Ten seconds synchronized unclosed: shift, then retry
// - Per-breaker max time, not in manual, nonzero
// - Mains timeout is always a warning
// - Tie timeout anomaly, plus alarm if managed
// - Manual: no regulation, still report synchronized
// - Offsets 0..100 percent, 50 is nominal
// - Assigned analogue input replaces stored voltage offset
// - Assigned analogue input replaces stored speed offset
// - Manual: close command closes breaker only if synchronism is seen at its rising edge
// - Action 0: keep loads, retry after acknowledge
// - Action 1: open tie, close mains unsynchronized
module gms_sequencer
   import gms_pkg::*;
#(
   parameter int CLK_PER_SEC = CYC_PER_SEC
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst,
   // Wishbone slave.
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Pins from the plant.
   input wire logic mains_breaker_sync_request_input,
   input wire logic tie_breaker_sync_request_input,
   input wire logic mains_breaker_closed_in,
   input wire logic tie_breaker_closed_in,
   input wire logic manual_close_cmd_in,
   // Measurement logic on this clock.
   input wire logic synchro_check_ok,
   input wire logic [PCT_W-1:0] analogue_voltage_offset_function,
   input wire logic [PCT_W-1:0] analogue_speed_offset_function,
   // Synchronization outputs.
   output logic tie_breaker_sync_enable_output,
   output logic mains_breaker_sync_enable_output,
   output logic sync_in_progress_output,
   output logic synchronized_output,
   // Status bits for the logic combiner.
   output logic mains_breaker_sync_status,
   output logic tie_breaker_sync_status,
   output logic synchronized_detected_status,
   // Regulation.
   output logic regulate_active,
   output logic freq_shift_active,
   output logic [PCT_W-1:0] voltage_offset_pct,
   output logic [PCT_W-1:0] speed_offset_pct,
   // Breaker commands.
   output logic close_mains_cmd,
   output logic close_tie_cmd,
   output logic close_mains_unsync_cmd,
   output logic open_tie_cmd,
   // Anomalies.
   output logic mains_breaker_sync_failure_warning,
   output logic tie_breaker_sync_failure_anomaly,
   output logic tie_breaker_sync_failure_alarm
);

   typedef struct packed {
      gms_state_e st;
      logic sel_mains;
      logic [CTRL_W-1:0] ctrl;
      logic [TIME_W-1:0] mains_max;
      logic [TIME_W-1:0] tie_max;
      logic [PCT_W-1:0] volt_set;
      logic [PCT_W-1:0] speed_set;
      logic [PCT_W-1:0] volt_eff;
      logic [PCT_W-1:0] speed_eff;
      logic mains_warn;
      logic tie_anom;
      logic tie_alarm;
      logic ack;
      logic [31:0] rdat;
      logic man_prev;
      logic close_mains;
      logic close_tie;
      logic [31:0] div;
      logic tick;
   } gms_core_s;

   gms_core_s q, d;

   logic req_m, req_t, closed_m, closed_t, man_cmd;
   logic auto_ok, supervise, start_m, start_t, in_sync, sync_run;
   logic cur_req, cur_closed, timeout, persist_exp, shift_exp;
   logic tmr_m_exp, tmr_t_exp;
   logic [TIME_W-1:0] tmr_m_el, tmr_t_el;

   initial begin
      if (CLK_PER_SEC < 2) $error("gms_sequencer: CLK_PER_SEC must be at least 2.");
   end

   function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] dat, input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) r[b*8 +: 8] = dat[b*8 +: 8];
      end
      return r;
   endfunction : wmerge

   function automatic logic [PCT_W-1:0] clamp_pct(input logic [PCT_W-1:0] v);
      return (v > PCT_MAX) ? PCT_MAX : v;
   endfunction : clamp_pct

   ////////////////////////////////////////////////////////////////////////////
   gms_sync3 #(.N(5)) u_pins (
      .sys_clk(sys_clk),
      .rst(rst),
      .pin({mains_breaker_sync_request_input, tie_breaker_sync_request_input,
            mains_breaker_closed_in, tie_breaker_closed_in, manual_close_cmd_in}),
      .level({req_m, req_t, closed_m, closed_t, man_cmd})
   );

   assign in_sync = (q.st == S_SYNC) || (q.st == S_SHIFT);
   assign sync_run = in_sync && !q.ctrl[CTRL_EXT_SYNC] && synchro_check_ok && (q.st == S_SYNC);

   gms_sec_timer u_tmr_mains (.sys_clk(sys_clk), .rst(rst), .tick(q.tick), .run(in_sync && q.sel_mains),
      .limit(q.mains_max), .elapsed(tmr_m_el), .expired(tmr_m_exp));
   gms_sec_timer u_tmr_tie (.sys_clk(sys_clk), .rst(rst), .tick(q.tick), .run(in_sync && !q.sel_mains),
      .limit(q.tie_max), .elapsed(tmr_t_el), .expired(tmr_t_exp));
   gms_sec_timer u_tmr_persist (.sys_clk(sys_clk), .rst(rst), .tick(q.tick), .run(sync_run),
      .limit(PERSIST_S), .elapsed(), .expired(persist_exp));
   // The shift phase has a fixed length, long enough for an outside synchro-check to see slip.
   gms_sec_timer u_tmr_shift (.sys_clk(sys_clk), .rst(rst), .tick(q.tick), .run(q.st == S_SHIFT),
      .limit(SHIFT_S), .elapsed(), .expired(shift_exp));

   ////////////////////////////////////////////////////////////////////////////
   assign auto_ok = (gms_mode_e'(q.ctrl[CTRL_MODE_LO +: 2]) != MODE_MAN) || q.ctrl[CTRL_AUTO_MAN];
   assign supervise = gms_mode_e'(q.ctrl[CTRL_MODE_LO +: 2]) != MODE_MAN;
   // A latched failure blocks a fresh start until software acknowledges it.
   assign start_m = req_m && q.ctrl[CTRL_PRECOND] && auto_ok && !q.mains_warn && !closed_m;
   assign start_t = req_t && q.ctrl[CTRL_PRECOND] && auto_ok && !q.tie_anom && !closed_t;
   assign cur_req = q.sel_mains ? req_m : req_t;
   assign cur_closed = q.sel_mains ? closed_m : closed_t;
   assign timeout = supervise && (q.sel_mains ? tmr_m_exp : tmr_t_exp);

   always_comb begin
      d = q;
      d.ack = 1'b0;
      d.close_mains = 1'b0;
      d.close_tie = 1'b0;
      d.man_prev = man_cmd;
      d.tick = 1'b0;
      if (q.div == 32'(CLK_PER_SEC - 1)) begin
         d.div = '0;
         d.tick = 1'b1;
      end else begin
         d.div = q.div + 32'h1;
      end
      d.volt_eff = q.ctrl[CTRL_AI_VOLT] ? clamp_pct(analogue_voltage_offset_function) : q.volt_set;
      d.speed_eff = q.ctrl[CTRL_AI_SPEED] ? clamp_pct(analogue_speed_offset_function) : q.speed_set;

      // Bus first, so an anomaly raised below in the same cycle wins over the acknowledge.
      if (wb_cyc_i && wb_stb_i && !q.ack) begin
         d.ack = 1'b1;
         d.rdat = '0;
         if (wb_we_i) begin
            case (wb_adr_i)
               ADR_CTRL: d.ctrl = CTRL_W'(wmerge(32'(q.ctrl), wb_dat_i, wb_sel_i));
               ADR_MAINS_MAX: d.mains_max = TIME_W'(wmerge(32'(q.mains_max), wb_dat_i, wb_sel_i));
               ADR_TIE_MAX: d.tie_max = TIME_W'(wmerge(32'(q.tie_max), wb_dat_i, wb_sel_i));
               ADR_OFFSET: begin
                  if (wb_sel_i[0]) d.volt_set = clamp_pct(wb_dat_i[OFS_VOLT_LO +: PCT_W]);
                  if (wb_sel_i[1]) d.speed_set = clamp_pct(wb_dat_i[OFS_SPEED_LO +: PCT_W]);
               end
               ADR_STATUS: begin
                  if (wb_sel_i[0] && wb_dat_i[ST_MAINS_WARN]) d.mains_warn = 1'b0;
                  if (wb_sel_i[0] && wb_dat_i[ST_TIE_ANOM]) begin
                     d.tie_anom = 1'b0;
                     d.tie_alarm = 1'b0;
                  end
               end
               default: ;
            endcase
         end else begin
            case (wb_adr_i)
               ADR_CTRL: d.rdat = 32'(q.ctrl);
               ADR_MAINS_MAX: d.rdat = 32'(q.mains_max);
               ADR_TIE_MAX: d.rdat = 32'(q.tie_max);
               ADR_OFFSET: d.rdat = {16'h0000, 1'b0, q.speed_set, 1'b0, q.volt_set};
               ADR_STATUS: d.rdat = {24'h000000, q.st == S_HOLD, q.st == S_SHIFT, synchro_check_ok,
                                     in_sync && !q.sel_mains, in_sync && q.sel_mains,
                                     q.tie_alarm, q.tie_anom, q.mains_warn};
               ADR_EFFECT: d.rdat = {16'h0000, 1'b0, q.speed_eff, 1'b0, q.volt_eff};
               default: d.rdat = '0;
            endcase
         end
      end

      // Manual mode: the operator's close command acts only if synchronism is seen at its rising edge.
      if (!auto_ok && man_cmd && !q.man_prev && synchro_check_ok) begin
         d.close_mains = q.ctrl[CTRL_MAN_SEL_MAINS];
         d.close_tie = !q.ctrl[CTRL_MAN_SEL_MAINS];
      end

      case (q.st)
         S_IDLE: begin
            if (start_m) begin
               d.st = S_SYNC;
               d.sel_mains = 1'b1;
            end else if (start_t) begin
               d.st = S_SYNC;
               d.sel_mains = 1'b0;
            end
         end
         S_SYNC, S_SHIFT: begin
            if (cur_closed || !cur_req || !auto_ok) begin
               d.st = S_IDLE;
            end else if (timeout) begin
               if (q.sel_mains) begin
                  d.mains_warn = 1'b1;
                  d.st = q.ctrl[CTRL_FAIL_ACT] ? S_UNSYNC : S_HOLD;
               end else begin
                  d.tie_anom = 1'b1;
                  d.tie_alarm = q.ctrl[CTRL_TIE_MANAGED];
                  d.st = S_IDLE;
               end
            end else if (q.st == S_SYNC && persist_exp) begin
               d.st = S_SHIFT;
            end else if (q.st == S_SHIFT && shift_exp) begin
               d.st = S_SYNC;
            end
         end
         S_HOLD: begin
            // Loads stay on the generators until the warning is acknowledged or the mains request drops.
            if (!q.mains_warn || !req_m) d.st = S_IDLE;
         end
         S_UNSYNC: begin
            // The tie request, if still present, restarts a synchronized tie close from idle.
            if (closed_m) d.st = S_IDLE;
         end
         default: d.st = S_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         q <= '0;
         q.st <= S_IDLE;
         q.ctrl <= CTRL_RST;
         q.mains_max <= TIME_RST;
         q.tie_max <= TIME_RST;
         q.volt_set <= PCT_NOMINAL;
         q.speed_set <= PCT_NOMINAL;
         q.volt_eff <= PCT_NOMINAL;
         q.speed_eff <= PCT_NOMINAL;
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign wb_ack_o = q.ack;
   assign wb_dat_o = q.rdat;
   assign mains_breaker_sync_enable_output = in_sync && q.sel_mains;
   assign tie_breaker_sync_enable_output = in_sync && !q.sel_mains;
   assign sync_in_progress_output = in_sync;
   // Drops five cycles after the breaker closes, once the filtered closed input ends the process; closing logic has to latch it.
   assign synchronized_output = in_sync && synchro_check_ok;
   assign mains_breaker_sync_status = mains_breaker_sync_enable_output;
   assign tie_breaker_sync_status = tie_breaker_sync_enable_output;
   assign synchronized_detected_status = synchro_check_ok;
   assign regulate_active = q.st == S_SYNC;
   assign freq_shift_active = q.st == S_SHIFT;
   assign voltage_offset_pct = q.volt_eff;
   assign speed_offset_pct = q.speed_eff;
   assign close_mains_cmd = q.close_mains;
   assign close_tie_cmd = q.close_tie;
   assign open_tie_cmd = (q.st == S_UNSYNC) && closed_t;
   assign close_mains_unsync_cmd = (q.st == S_UNSYNC) && !closed_t && !closed_m;
   assign mains_breaker_sync_failure_warning = q.mains_warn;
   assign tie_breaker_sync_failure_anomaly = q.tie_anom;
   assign tie_breaker_sync_failure_alarm = q.tie_alarm;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   property p_start;
      q.st == S_IDLE && start_m |=> mains_breaker_sync_enable_output && regulate_active;
   endproperty
   a_start: assert property (p_start) else $error("Mains sync did not start.");

   property p_tie_end;
      tie_breaker_sync_enable_output && closed_t |=> !tie_breaker_sync_enable_output;
   endproperty
   a_tie_end: assert property (p_tie_end) else $error("Tie enable stayed after close.");

   property p_mains_end;
      mains_breaker_sync_enable_output && !req_m |=> !sync_in_progress_output;
   endproperty
   a_mains_end: assert property (p_mains_end) else $error("Mains sync did not end.");

   property p_synced;
      synchronized_output |-> sync_in_progress_output && synchronized_detected_status;
   endproperty
   a_synced: assert property (p_synced) else $error("Synchronized out of process.");

   property p_no_auto;
      q.st == S_IDLE && !auto_ok |=> q.st == S_IDLE;
   endproperty
   a_no_auto: assert property (p_no_auto) else $error("Sync started in plain manual.");

   property p_persist;
      q.st == S_SYNC && persist_exp && cur_req && !cur_closed && !timeout && auto_ok
         |=> freq_shift_active ##1 !regulate_active;
   endproperty
   a_persist: assert property (p_persist) else $error("No frequency shift after persistence.");

   property p_man_nosuper;
      !supervise |=> !$rose(q.mains_warn) && !$rose(q.tie_anom);
   endproperty
   a_man_nosuper: assert property (p_man_nosuper) else $error("Timeout raised in manual.");

   sequence s_mains_to;
      in_sync && q.sel_mains && timeout && cur_req && !cur_closed && auto_ok;
   endsequence

   property p_warn_hold;
      s_mains_to and !q.ctrl[CTRL_FAIL_ACT] |=> mains_breaker_sync_failure_warning && q.st == S_HOLD;
   endproperty
   a_warn_hold: assert property (p_warn_hold) else $error("Action 0 did not hold loads.");

   property p_act1;
      s_mains_to and q.ctrl[CTRL_FAIL_ACT] |=> q.st == S_UNSYNC && !sync_in_progress_output;
   endproperty
   a_act1: assert property (p_act1) else $error("Action 1 did not go unsynchronized.");

   property p_tie_alarm;
      $rose(q.tie_anom) |-> q.tie_alarm == $past(q.ctrl[CTRL_TIE_MANAGED]);
   endproperty
   a_tie_alarm: assert property (p_tie_alarm) else $error("Tie anomaly severity wrong.");

   property p_volt_sel;
      !q.ctrl[CTRL_AI_VOLT] ##1 !q.ctrl[CTRL_AI_VOLT] |-> voltage_offset_pct == $past(q.volt_set);
   endproperty
   a_volt_sel: assert property (p_volt_sel) else $error("Stored voltage offset not used.");

   property p_man_close;
      !auto_ok && man_cmd && !q.man_prev && synchro_check_ok && q.ctrl[CTRL_MAN_SEL_MAINS] |=> close_mains_cmd;
   endproperty
   a_man_close: assert property (p_man_close) else $error("Manual close not issued.");

endmodule : gms_sequencer

// [tb/gms_plant_model.sv]
`timescale 1ns/1ns
module gms_plant_model (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst,
   // Bench control.
   input wire logic close_on_sync,
   input wire logic [2:0] lat,
   // Device outputs.
   input wire logic synced,
   input wire logic mains_en,
   input wire logic close_m,
   input wire logic close_t,
   input wire logic close_mu,
   input wire logic open_t,
   // Breaker states.
   output logic mains_closed,
   output logic tie_closed
);
   logic [2:0] n;
   wire logic hit = close_on_sync && synced && n == lat;
   // Closing after lat cycles of synchronism models slow external closing logic.
   always @(posedge sys_clk) begin
      n <= (close_on_sync && synced) ? n + 3'h1 : 3'h0;
      if (rst) begin
         mains_closed <= 1'b0;
         tie_closed <= 1'b0;
      end else begin
         if (close_m || close_mu || (hit && mains_en)) mains_closed <= 1'b1;
         if (close_t || (hit && !mains_en)) tie_closed <= 1'b1;
         if (open_t) tie_closed <= 1'b0;
      end
   end
endmodule : gms_plant_model

// [tb/gms_sequencer_tb.sv]
`timescale 1ns/1ns
module gms_sequencer_tb
   import gms_pkg::*;
;
   localparam int CPS = 10;
   logic sys_clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, req_m = 0, req_t = 0, man = 0, sck = 0, cos = 0;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h0, lf = 32'h17a4de72;
   logic [6:0] av = 7'h00, sv = 7'h00;
   logic [2:0] lat = 3'h1;
   logic [9:0] md [4] = '{10'h021, 10'h022, 10'h023, 10'h024};
   wire logic [31:0] rdat;
   wire logic [6:0] vo, so;
   wire logic ack, ten, men, inp, syo, mst, tst, sds, reg_a, shf, cm, ct, cmu, ot, wrn, anm, alm, mcl, tcl;
   wire logic [10:0] mon = {cm, tcl, mcl, ct, anm, wrn, shf, syo, inp, ten, men};
   int bad_count = 0, n_checks = 0, cnt = 0;
   logic [31:0] q[$];

   gms_sequencer #(.CLK_PER_SEC(CPS)) u_gms_sequencer (.sys_clk(sys_clk), .rst(rst),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .mains_breaker_sync_request_input(req_m),
      .tie_breaker_sync_request_input(req_t), .mains_breaker_closed_in(mcl), .tie_breaker_closed_in(tcl),
      .manual_close_cmd_in(man), .synchro_check_ok(sck), .analogue_voltage_offset_function(av),
      .analogue_speed_offset_function(sv), .tie_breaker_sync_enable_output(ten),
      .mains_breaker_sync_enable_output(men), .sync_in_progress_output(inp), .synchronized_output(syo),
      .mains_breaker_sync_status(mst), .tie_breaker_sync_status(tst), .synchronized_detected_status(sds),
      .regulate_active(reg_a), .freq_shift_active(shf), .voltage_offset_pct(vo), .speed_offset_pct(so),
      .close_mains_cmd(cm), .close_tie_cmd(ct), .close_mains_unsync_cmd(cmu), .open_tie_cmd(ot),
      .mains_breaker_sync_failure_warning(wrn), .tie_breaker_sync_failure_anomaly(anm),
      .tie_breaker_sync_failure_alarm(alm));
   gms_plant_model u_gms_plant_model (.sys_clk(sys_clk), .rst(rst), .close_on_sync(cos), .lat(lat),
      .synced(syo), .mains_en(men), .close_m(cm), .close_t(ct), .close_mu(cmu), .open_t(ot),
      .mains_closed(mcl), .tie_closed(tcl));

   always #10 sys_clk = ~sys_clk;
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [6:0] rnd();
      lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
      return 7'(lf % 101);
   endfunction : rnd
   task automatic chk_pin(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk_pin
   task automatic chk_rd(input logic [31:0] g);
      chk_pin(g, q.size() > 0 ? q.pop_front() : 32'hxxxxxxxx);
   endtask : chk_rd
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : stop_test
   // Every wait is bounded so a stuck sequencer ends the run instead of hanging it.
   task automatic wt(input int b, input logic v, input int lim);
      int i;
      for (i = 0; i < lim && mon[b] !== v; i++) @(posedge sys_clk);
      cnt = i;
      if (mon[b] !== v) begin
         bad_count++;
         stop_test();
      end
   endtask : wt
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge sys_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      i = 0;
      do begin
         @(posedge sys_clk);
         i++;
      end while (ack !== 1'b1 && i < 50);
      if (ack !== 1'b1) begin
         bad_count++;
         stop_test();
      end
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      q.push_back(e);
      wb(1'b0, a, 32'h0);
   endtask : rd
   always @(posedge sys_clk) if (ack === 1'b1 && we === 1'b0) chk_rd(rdat);
   initial begin
      repeat (20000) @(posedge sys_clk);
      bad_count++;
      stop_test();
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [6:0] t;
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      rd(ADR_CTRL, 32'h0);
      rd(8'h18, 32'h0);
      rd(ADR_EFFECT, 32'h3232);
      t = rnd();
      wr(ADR_OFFSET, {17'h0, t, 8'h7f});
      rd(ADR_EFFECT, {17'h0, t, 1'b0, PCT_MAX});
      av <= rnd();
      sv <= rnd();
      wr(ADR_CTRL, 32'hc0);
      rd(ADR_EFFECT, {17'h0, sv, 1'b0, av});
      chk_pin({so, vo}, {sv, av});
      av <= 7'h7f;
      repeat (2) @(posedge sys_clk);
      chk_pin(vo, PCT_MAX);
      foreach (md[k]) begin
         wr(ADR_CTRL, {22'h0, md[k]});
         req_m <= 1'b1;
         wt(0, 1'b1, 20);
         chk_pin({inp, mst, tst, sds}, 4'b1100);
         rd(ADR_STATUS, 32'h08);
         req_m <= 1'b0;
         wt(2, 1'b0, 20);
      end
      cos <= 1'b1;
      lat <= 3'(1 + rnd() % 4);
      wr(ADR_CTRL, 32'h21);
      req_t <= 1'b1;
      wt(1, 1'b1, 20);
      sck <= 1'b1;
      wt(3, 1'b1, 5);
      chk_pin({tst, reg_a, men}, 3'b110);
      wt(9, 1'b1, 20);
      wt(1, 1'b0, 10);
      chk_pin(syo, 1'b0);
      req_t <= 1'b0;
      cos <= 1'b0;
      req_m <= 1'b1;
      wt(0, 1'b1, 20);
      wt(4, 1'b1, 130);
      chk_pin(cnt >= 9 * CPS && cnt <= 11 * CPS, 1'b1);
      wt(4, 1'b0, 30);
      chk_pin(reg_a, 1'b1);
      wr(ADR_CTRL, 32'h221);
      cnt = 0;
      repeat (120) begin
         @(posedge sys_clk);
         if (shf !== 1'b0) cnt++;
      end
      chk_pin(cnt, 32'h0);
      req_m <= 1'b0;
      sck <= 1'b0;
      wt(0, 1'b0, 20);
      wr(ADR_MAINS_MAX, 32'h3);
      req_m <= 1'b1;
      wt(0, 1'b1, 20);
      wt(5, 1'b1, 60);
      chk_pin(cnt >= 2 * CPS && cnt <= 4 * CPS, 1'b1);
      rd(ADR_STATUS, 32'h81);
      wr(ADR_STATUS, 32'h1);
      wt(0, 1'b1, 20);
      chk_pin(wrn, 1'b0);
      req_m <= 1'b0;
      wt(0, 1'b0, 20);
      wr(ADR_CTRL, 32'h39);
      req_m <= 1'b1;
      req_t <= 1'b1;
      wt(5, 1'b1, 80);
      wt(9, 1'b0, 20);
      wt(8, 1'b1, 30);
      req_m <= 1'b0;
      wt(1, 1'b1, 30);
      wr(ADR_TIE_MAX, 32'h2);
      wt(6, 1'b1, 60);
      rd(ADR_STATUS, 32'h07);
      wr(ADR_CTRL, 32'h29);
      wr(ADR_STATUS, 32'h2);
      wt(6, 1'b0, 5);
      wt(6, 1'b1, 80);
      rd(ADR_STATUS, 32'h03);
      wr(ADR_CTRL, 32'h0);
      wr(ADR_STATUS, 32'h3);
      sck <= 1'b1;
      repeat (8) @(posedge sys_clk);
      chk_pin({ten, inp, reg_a, syo, sds}, 5'b00001);
      man <= 1'b1;
      wt(7, 1'b1, 20);
      wt(9, 1'b1, 20);
      man <= 1'b0;
      wr(ADR_CTRL, 32'h100);
      repeat (6) @(posedge sys_clk);
      man <= 1'b1;
      wt(10, 1'b1, 20);
      stop_test();
   end
endmodule : gms_sequencer_tb
